/* design/i2r_regs.sv */
`timescale 1ns/1ps
`include "i2r_defines.svh"
module i2r_regs #(
  parameter int AW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic evt_nack,
  input wire logic evt_stop,
  input wire logic evt_start,
  input wire logic evt_arb_lost,
  input wire logic [1:0] port_rx_done,
  input wire i2r_pkg::i2r_byte_type [1:0] port_rx_char,
  input wire logic [1:0] port_tx_take,
  output i2r_pkg::i2r_byte_type [1:0] port_tx_char,
  output logic [1:0] port_tx_pending,
  output logic [AW-1:0] target_address_field,
  output i2r_pkg::i2r_addr_mode_type addr_mode,
  output logic master_en,
  output logic irq
);
  import i2r_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  function automatic i2r_byte_type flag_byte(input logic tx, input logic rx);
    i2r_byte_type b;
    b = `I2R_RST_BYTE;
    b[`I2R_BIT_TXF] = tx;
    b[`I2R_BIT_RXF] = rx;
    return b;
  endfunction : flag_byte

  logic [AW-1:0] sa;
  logic [`I2R_EV_MSB:0] ev_en;
  logic [`I2R_EV_MSB:0] ev_sts;
  logic [`I2R_EV_MSB:0] ev_in;
  logic [1:0] tx_en;
  logic [1:0] rx_en;
  logic [1:0] tx_flag;
  logic [1:0] rx_flag;
  logic [1:0] tx_wr;
  logic [1:0] rx_rd;
  logic [1:0] flag_wr;
  i2r_byte_type [1:0] rx_data;
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic [31:0] next_prdata;
  logic next_err;
  logic [AW-1:0] next_target;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // zero wait states: read data is captured in the setup cycle
  assign pready = psel && penable;

  always_comb begin
    next_prdata = `I2R_RST_WORD;
    next_err = 1'b0;
    unique case (paddr)
      `I2R_OFF_TADDR: next_prdata[AW-1:0] = sa;
      `I2R_OFF_EVEN: next_prdata[`I2R_EV_MSB:0] = ev_en;
      `I2R_OFF_EVSTS: next_prdata[`I2R_EV_MSB:0] = ev_sts;
      `I2R_OFF_CTRL: begin
        next_prdata[`I2R_BIT_TEN] = addr_mode;
        next_prdata[`I2R_BIT_MST] = master_en;
      end
      // bits owned by other blocks read as zero
      `I2R_OFF_P0IE: next_prdata[7:0] = flag_byte(tx_en[0], rx_en[0]); // [RULE6]
      `I2R_OFF_P0IFG: next_prdata[7:0] = flag_byte(tx_flag[0], rx_flag[0]);
      `I2R_OFF_P1IE: next_prdata[7:0] = flag_byte(tx_en[1], rx_en[1]); // [RULE7]
      `I2R_OFF_P1IFG: next_prdata[7:0] = flag_byte(tx_flag[1], rx_flag[1]);
      `I2R_OFF_P0RX: next_prdata[7:0] = rx_data[0];
      `I2R_OFF_P0TX: next_prdata[7:0] = port_tx_char[0];
      `I2R_OFF_P1RX: next_prdata[7:0] = rx_data[1];
      `I2R_OFF_P1TX: next_prdata[7:0] = port_tx_char[1];
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `I2R_RST_WORD;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? `I2R_RST_WORD : next_prdata;
      pslverr <= next_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa <= `I2R_RST_TADDR;
    end else if (wr_acc && hit(paddr, `I2R_OFF_TADDR)) begin
      sa <= pwdata[AW-1:0]; // [RULE1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_mode <= I2R_MODE_7BIT;
      master_en <= 1'b0;
    end else if (wr_acc && hit(paddr, `I2R_OFF_CTRL)) begin
      addr_mode <= i2r_addr_mode_type'(pwdata[`I2R_BIT_TEN]);
      master_en <= pwdata[`I2R_BIT_MST];
    end
  end

  always_comb begin
    next_target = '0;
    if (master_en) begin // [RULE1]
      if (addr_mode == I2R_MODE_10BIT) begin
        next_target = sa; // [RULE3]
      end else begin
        next_target[`I2R_A7_MSB:0] = sa[`I2R_A7_MSB:0]; // [RULE2]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_address_field <= `I2R_RST_TADDR;
    end else begin
      target_address_field <= next_target;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_en <= `I2R_RST_EV; // [RULE15]
    end else if (wr_acc && hit(paddr, `I2R_OFF_EVEN)) begin
      ev_en <= pwdata[`I2R_EV_MSB:0]; // [RULE4] [RULE5]
    end
  end

  always_comb begin
    ev_in = `I2R_RST_EV;
    ev_in[`I2R_BIT_NACK] = evt_nack;
    ev_in[`I2R_BIT_STOP] = evt_stop;
    ev_in[`I2R_BIT_START] = evt_start;
    ev_in[`I2R_BIT_ARB] = evt_arb_lost;
  end

  // write one to clear; an event in the same cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_sts <= `I2R_RST_EV;
    end else if (wr_acc && hit(paddr, `I2R_OFF_EVSTS)) begin
      ev_sts <= (ev_sts & ~pwdata[`I2R_EV_MSB:0]) | ev_in;
    end else begin
      ev_sts <= ev_sts | ev_in;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_port
    localparam logic [7:0] OFF_IE = (i == 0) ? `I2R_OFF_P0IE : `I2R_OFF_P1IE;
    localparam logic [7:0] OFF_FLAG = (i == 0) ? `I2R_OFF_P0IFG : `I2R_OFF_P1IFG;
    localparam logic [7:0] OFF_RX = (i == 0) ? `I2R_OFF_P0RX : `I2R_OFF_P1RX;
    localparam logic [7:0] OFF_TX = (i == 0) ? `I2R_OFF_P0TX : `I2R_OFF_P1TX;

    assign tx_wr[i] = wr_acc && hit(paddr, OFF_TX);
    assign rx_rd[i] = rd_acc && hit(paddr, OFF_RX);
    assign flag_wr[i] = wr_acc && hit(paddr, OFF_FLAG);
    assign port_tx_pending[i] = !tx_flag[i];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_en[i] <= `I2R_RST_EN; // [RULE15]
        rx_en[i] <= `I2R_RST_EN;
      end else if (wr_acc && hit(paddr, OFF_IE)) begin
        tx_en[i] <= pwdata[`I2R_BIT_TXF]; // [RULE6] [RULE7]
        rx_en[i] <= pwdata[`I2R_BIT_RXF];
      end
    end

    i2r_port_flags u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .tx_write(tx_wr[i]),
      .tx_wdata(pwdata[7:0]),
      .rx_read(rx_rd[i]),
      .flag_write(flag_wr[i]),
      .flag_wdata_tx(pwdata[`I2R_BIT_TXF]),
      .flag_wdata_rx(pwdata[`I2R_BIT_RXF]),
      .rx_done(port_rx_done[i]),
      .rx_char(port_rx_char[i]),
      .tx_take(port_tx_take[i]),
      .tx_flag(tx_flag[i]),
      .rx_flag(rx_flag[i]),
      .tx_data(port_tx_char[i]),
      .rx_data(rx_data[i])
    );
  end

  assign irq = |(ev_sts & ev_en) || |(tx_flag & tx_en) || |(rx_flag & rx_en); // [RULE14]

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_master_only;
    !master_en |=> target_address_field == '0;
  endproperty
  a_master_only: assert property (p_master_only) else $error("target address seen outside master"); // [RULE1]

  property p_addr7;
    (wr_acc && hit(paddr, `I2R_OFF_TADDR) && master_en && addr_mode == I2R_MODE_7BIT)
      ##1 (master_en && addr_mode == I2R_MODE_7BIT)
      |=> target_address_field == {{(AW-7){1'b0}}, $past(pwdata[`I2R_A7_MSB:0], 2)};
  endproperty
  a_addr7: assert property (p_addr7) else $error("7-bit address not justified"); // [RULE2]

  property p_addr10;
    (wr_acc && hit(paddr, `I2R_OFF_TADDR) && master_en && addr_mode == I2R_MODE_10BIT)
      ##1 (master_en && addr_mode == I2R_MODE_10BIT)
      |=> target_address_field == $past(pwdata[AW-1:0], 2);
  endproperty
  a_addr10: assert property (p_addr10) else $error("10-bit address wrong"); // [RULE3]

  property p_nack_irq;
    evt_nack && ev_en[`I2R_BIT_NACK] && !wr_acc |=> irq && ev_sts[`I2R_BIT_NACK];
  endproperty
  a_nack_irq: assert property (p_nack_irq) else $error("nack event gave no interrupt"); // [RULE4]

  property p_arb_irq;
    evt_arb_lost && ev_en[`I2R_BIT_ARB] && !wr_acc |=> irq && ev_sts[`I2R_BIT_ARB];
  endproperty
  a_arb_irq: assert property (p_arb_irq) else $error("arb-lost event gave no interrupt"); // [RULE5]

  property p_stop_irq;
    evt_stop && ev_en[`I2R_BIT_STOP] && !wr_acc |=> irq && ev_sts[`I2R_BIT_STOP];
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop event gave no interrupt"); // [RULE4]

  property p_start_irq;
    evt_start && ev_en[`I2R_BIT_START] && !wr_acc |=> irq && ev_sts[`I2R_BIT_START];
  endproperty
  a_start_irq: assert property (p_start_irq) else $error("start event gave no interrupt"); // [RULE5]

  property p_p0ie_read;
    setup && !pwrite && hit(paddr, `I2R_OFF_P0IE)
      |=> prdata == 32'(flag_byte($past(tx_en[0]), $past(rx_en[0])));
  endproperty
  a_p0ie_read: assert property (p_p0ie_read) else $error("port 0 enable layout wrong"); // [RULE6]

  property p_p1ie_read;
    setup && !pwrite && hit(paddr, `I2R_OFF_P1IE)
      |=> prdata == 32'(flag_byte($past(tx_en[1]), $past(rx_en[1])));
  endproperty
  a_p1ie_read: assert property (p_p1ie_read) else $error("port 1 enable layout wrong"); // [RULE7]

  property p_tx0_set;
    port_tx_take[0] && !tx_wr[0] |=> tx_flag[0] && port_tx_pending[0] == 1'b0;
  endproperty
  a_tx0_set: assert property (p_tx0_set) else $error("port 0 tx flag not set"); // [RULE8]

  property p_rx0_set;
    port_rx_done[0] |=> rx_flag[0] && rx_data[0] == $past(port_rx_char[0]);
  endproperty
  a_rx0_set: assert property (p_rx0_set) else $error("port 0 rx flag not set"); // [RULE9]

  property p_tx1_set;
    port_tx_take[1] && !tx_wr[1] |=> tx_flag[1];
  endproperty
  a_tx1_set: assert property (p_tx1_set) else $error("port 1 tx flag not set"); // [RULE10]

  property p_rx1_set;
    port_rx_done[1] |=> rx_flag[1] && rx_data[1] == $past(port_rx_char[1]);
  endproperty
  a_rx1_set: assert property (p_rx1_set) else $error("port 1 rx flag not set"); // [RULE11]

  property p_rx_clear;
    rx_rd[0] && !port_rx_done[0] |=> !rx_flag[0];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx read did not clear flag"); // [RULE12]

  property p_tx_clear;
    tx_wr[1] ##1 !port_tx_take[1] && !flag_wr[1] |=> !tx_flag[1];
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx write did not hold flag low"); // [RULE13]

  property p_irq_cause;
    $rose(irq) |-> (ev_sts & ev_en) != '0 || (tx_flag & tx_en) != '0 || (rx_flag & rx_en) != '0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled flag"); // [RULE14]

  property p_reset_vals;
    $rose(presetn) |-> tx_flag == 2'b11 && rx_flag == 2'b00 && tx_en == 2'b00 && ev_en == '0 && !irq;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // [RULE15]

  c_nack_irq: cover property (evt_nack ##1 irq);
  c_rx_read: cover property (port_rx_done[1] ##[1:20] rx_rd[1]);
  c_tx_cycle: cover property (tx_wr[0] ##[1:20] port_tx_take[0]);
  c_bad_addr: cover property (pslverr && pready);
endmodule : i2r_regs

/* design/i2r_defines.svh */
`ifndef I2R_DEFINES_SVH
`define I2R_DEFINES_SVH
// Summary of operation
// [RULE1] ten-bit target address, used only as master
// [RULE2] 7-bit mode: bit 6 MSB, 9-7 ignored
// [RULE3] 10-bit mode: bit 9 MSB, all bits
// [RULE4] event enables: nack bit 3, stop bit 2
// [RULE5] event enables: start bit 1, arb-lost bit 0
// [RULE6] port 0 shared enables: tx 3, rx 2; the code gives port 0 its own enable register, apart from port 1
// [RULE7] port 1 enables: tx 3, rx 2
// [RULE8] port 0 tx flag set when buffer empty
// [RULE9] port 0 rx flag set on received character
// [RULE10] port 1 tx flag set when buffer empty
// [RULE11] port 1 rx flag set on received character
// [RULE12] reading rx buffer clears rx flag
// [RULE13] writing tx buffer clears tx flag
// [RULE14] interrupt only when flag and enable set
// [RULE15] reset: tx flags one, rest zero
`define I2R_OFF_TADDR 8'h00
`define I2R_OFF_EVEN 8'h04
`define I2R_OFF_EVSTS 8'h08
`define I2R_OFF_CTRL 8'h0C
`define I2R_OFF_P0IE 8'h10
`define I2R_OFF_P0IFG 8'h14
`define I2R_OFF_P1IE 8'h18
`define I2R_OFF_P1IFG 8'h1C
`define I2R_OFF_P0RX 8'h20
`define I2R_OFF_P0TX 8'h24
`define I2R_OFF_P1RX 8'h28
`define I2R_OFF_P1TX 8'h2C
`define I2R_BIT_NACK 3
`define I2R_BIT_STOP 2
`define I2R_BIT_START 1
`define I2R_BIT_ARB 0
`define I2R_EV_MSB 3
`define I2R_BIT_TXF 3
`define I2R_BIT_RXF 2
`define I2R_BIT_TEN 0
`define I2R_BIT_MST 1
`define I2R_A7_MSB 6
`define I2R_RST_TADDR 10'h000
`define I2R_RST_EV 4'h0
`define I2R_RST_TXF 1'b1
`define I2R_RST_RXF 1'b0
`define I2R_RST_EN 1'b0
`define I2R_RST_BYTE 8'h00
`define I2R_RST_WORD 32'h0000_0000
`endif

/* design/i2r_pkg.sv */
package i2r_pkg;
  typedef enum logic {I2R_MODE_7BIT = 1'b0, I2R_MODE_10BIT = 1'b1} i2r_addr_mode_type;
  typedef logic [7:0] i2r_byte_type;
endpackage : i2r_pkg

/* design/i2r_port_flags.sv */
`timescale 1ns/1ps
`include "i2r_defines.svh"
module i2r_port_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_write,
  input wire i2r_pkg::i2r_byte_type tx_wdata,
  input wire logic rx_read,
  input wire logic flag_write,
  input wire logic flag_wdata_tx,
  input wire logic flag_wdata_rx,
  input wire logic rx_done,
  input wire i2r_pkg::i2r_byte_type rx_char,
  input wire logic tx_take,
  output logic tx_flag,
  output logic rx_flag,
  output i2r_pkg::i2r_byte_type tx_data,
  output i2r_pkg::i2r_byte_type rx_data
);
  import i2r_pkg::*;

  // a write in the same cycle as a take refills the buffer, so it stays full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_flag <= `I2R_RST_TXF; // [RULE15]
    end else if (tx_write) begin
      tx_flag <= 1'b0; // [RULE13]
    end else if (tx_take) begin
      tx_flag <= 1'b1; // [RULE8] [RULE10]
    end else if (flag_write) begin
      tx_flag <= flag_wdata_tx;
    end
  end

  // new character wins over a read that clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flag <= `I2R_RST_RXF; // [RULE15]
    end else if (rx_done) begin
      rx_flag <= 1'b1; // [RULE9] [RULE11]
    end else if (rx_read) begin
      rx_flag <= 1'b0; // [RULE12]
    end else if (flag_write) begin
      rx_flag <= flag_wdata_rx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= `I2R_RST_BYTE;
    end else if (tx_write) begin
      tx_data <= tx_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= `I2R_RST_BYTE;
    end else if (rx_done) begin
      rx_data <= rx_char;
    end
  end
endmodule : i2r_port_flags

/* verif/i2r_engine_model.sv */
`timescale 1ns/1ps
module i2r_engine_model (
  input wire logic pclk,
  output logic [3:0] evt,
  output logic [1:0] port_rx_done,
  output i2r_pkg::i2r_byte_type [1:0] port_rx_char,
  output logic [1:0] port_tx_take
);
  import i2r_pkg::*;
  initial begin
    evt = 4'h0;
    port_rx_done = 2'h0;
    port_rx_char = 16'h5AA5;
    port_tx_take = 2'h0;
  end
  // every task waits first, so both prompt and slow engines are exercised
  task automatic pulse_event(input int idx, input int wait_cycles);
    repeat (wait_cycles) @(posedge pclk);
    @(posedge pclk);
    evt[idx] <= 1'b1;
    @(posedge pclk);
    evt[idx] <= 1'b0;
  endtask : pulse_event
  task automatic rx_char_in(input int port, input i2r_byte_type ch, input int wait_cycles);
    repeat (wait_cycles) @(posedge pclk);
    @(posedge pclk);
    port_rx_done[port] <= 1'b1;
    port_rx_char[port] <= ch;
    @(posedge pclk);
    port_rx_done[port] <= 1'b0;
    // stale data is not held, so a late sample is caught
    port_rx_char[port] <= ~ch;
  endtask : rx_char_in
  task automatic tx_take(input int port, input int wait_cycles);
    repeat (wait_cycles) @(posedge pclk);
    @(posedge pclk);
    port_tx_take[port] <= 1'b1;
    @(posedge pclk);
    port_tx_take[port] <= 1'b0;
  endtask : tx_take
endmodule : i2r_engine_model

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "i2r_defines.svh"
module testbench;
  import i2r_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, master_en, irq;
  i2r_addr_mode_type addr_mode;
  logic [9:0] target_address_field;
  logic [3:0] evt;
  logic [1:0] port_rx_done, port_tx_take, port_tx_pending;
  i2r_byte_type [1:0] port_rx_char, port_tx_char;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] ie, fl, rxa, txa, ch;
  always #5 pclk = ~pclk;
  i2r_regs #(.AW(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_nack(evt[3]), .evt_stop(evt[2]), .evt_start(evt[1]), .evt_arb_lost(evt[0]),
    .port_rx_done(port_rx_done), .port_rx_char(port_rx_char), .port_tx_take(port_tx_take),
    .port_tx_char(port_tx_char), .port_tx_pending(port_tx_pending), .target_address_field(target_address_field),
    .addr_mode(addr_mode), .master_en(master_en), .irq(irq));
  i2r_engine_model eng_u (.pclk(pclk), .evt(evt), .port_rx_done(port_rx_done), .port_rx_char(port_rx_char),
    .port_tx_take(port_tx_take));
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(what, exp, rd);
    chk_word({what, " err"}, 32'h0, {31'h0, err});
  endtask : rd_chk
  task automatic irq_chk(input string what, input logic exp);
    @(negedge pclk);
    chk_word(what, {31'h0, exp}, {31'h0, irq});
  endtask : irq_chk
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("taddr rst", `I2R_OFF_TADDR, 32'h0);
    rd_chk("even rst", `I2R_OFF_EVEN, 32'h0);
    rd_chk("p0ie rst", `I2R_OFF_P0IE, 32'h0);
    rd_chk("p0ifg rst", `I2R_OFF_P0IFG, 32'h08);
    rd_chk("p1ie rst", `I2R_OFF_P1IE, 32'h0);
    rd_chk("p1ifg rst", `I2R_OFF_P1IFG, 32'h08);
    irq_chk("irq rst", 1'b0);
    apb(1'b0, 8'h30, 32'h0);
    chk_word("unmapped err", 32'h1, {31'h0, err});
    chk_word("unmapped data", 32'h0, rd);
    $display("reset test done");
    wr(`I2R_OFF_TADDR, 32'hFFFF_FFFF);
    rd_chk("taddr width", `I2R_OFF_TADDR, 32'h3FF);
    // mode first, so the address write itself lands while mastering
    wr(`I2R_OFF_CTRL, 32'h3);
    wr(`I2R_OFF_TADDR, 32'h3A5);
    repeat (2) @(negedge pclk);
    chk_word("addr 10", 32'h3A5, {22'h0, target_address_field});
    chk_word("mode 10", 32'h3, {30'h0, master_en, addr_mode});
    wr(`I2R_OFF_CTRL, 32'h2);
    repeat (2) @(negedge pclk);
    chk_word("addr 7", 32'h025, {22'h0, target_address_field});
    wr(`I2R_OFF_TADDR, 32'h2C3);
    repeat (2) @(negedge pclk);
    chk_word("addr 7 new", 32'h043, {22'h0, target_address_field});
    wr(`I2R_OFF_CTRL, 32'h1);
    rd_chk("ctrl", `I2R_OFF_CTRL, 32'h1);
    chk_word("addr slave", 32'h0, {22'h0, target_address_field});
    rd_chk("taddr kept", `I2R_OFF_TADDR, 32'h2C3);
    $display("address test done");
    for (int i = 0; i < 4; i++) begin
      eng_u.pulse_event(i, i);
      irq_chk("ev masked", 1'b0);
      rd_chk("ev status", `I2R_OFF_EVSTS, 32'h1 << i);
      wr(`I2R_OFF_EVEN, 32'h1 << i);
      irq_chk("ev irq", 1'b1);
      rd_chk("ev enable", `I2R_OFF_EVEN, 32'h1 << i);
      wr(`I2R_OFF_EVSTS, 32'h1 << i);
      irq_chk("ev cleared", 1'b0);
      // event while enabled: the interrupt must come back on its own
      eng_u.pulse_event(i, 1);
      irq_chk("ev irq live", 1'b1);
      wr(`I2R_OFF_EVSTS, 32'h1 << i);
      irq_chk("ev cleared again", 1'b0);
      wr(`I2R_OFF_EVEN, 32'h0);
    end
    $display("event test done");
    for (int p = 0; p < 2; p++) begin
      ie = p ? `I2R_OFF_P1IE : `I2R_OFF_P0IE;
      fl = p ? `I2R_OFF_P1IFG : `I2R_OFF_P0IFG;
      rxa = p ? `I2R_OFF_P1RX : `I2R_OFF_P0RX;
      txa = p ? `I2R_OFF_P1TX : `I2R_OFF_P0TX;
      ch = 8'hA5 ^ {7'h0, p[0]};
      wr(ie, 32'h08);
      irq_chk("tx irq", 1'b1);
      wr(txa, {24'h0, ~ch});
      irq_chk("tx irq off", 1'b0);
      chk_word("tx out", {23'h0, 1'b1, ~ch}, {23'h0, port_tx_pending[p], port_tx_char[p]});
      rd_chk("tx flag off", fl, 32'h00);
      rd_chk("tx data", txa, {24'h0, ~ch});
      eng_u.tx_take(p, 3 * p);
      rd_chk("tx flag on", fl, 32'h08);
      wr(ie, 32'h04);
      rd_chk("rx enable", ie, 32'h04);
      irq_chk("rx idle", 1'b0);
      eng_u.rx_char_in(p, ch, 2 * p);
      irq_chk("rx irq", 1'b1);
      rd_chk("rx flag on", fl, 32'h0C);
      rd_chk("rx data", rxa, {24'h0, ch});
      rd_chk("rx flag off", fl, 32'h08);
      irq_chk("rx irq off", 1'b0);
      // software may write the flags directly
      wr(fl, 32'h04);
      rd_chk("flag write", fl, 32'h04);
      irq_chk("flag write irq", 1'b1);
      wr(fl, 32'h08);
      irq_chk("flag restore irq", 1'b0);
      wr(ie, 32'h0);
    end
    $display("port test done");
    results();
  end
endmodule : testbench
